// >>> shared/timer_watchdog_pkg.sv
// timer_watchdog_pkg: register map, field positions, reset values and carriers
// assumes an 8-bit register port clocked by the internal clock (25 MHz)
package timer_watchdog_pkg;

  // register offsets
  localparam logic [7:0] ADDR_FLAG       = 8'hF2;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hF8;
  localparam logic [7:0] ADDR_COUNT_LOW  = 8'hF9;
  localparam logic [7:0] ADDR_PRESCALE   = 8'hFA;
  localparam logic [7:0] ADDR_CONTROL    = 8'hFB;
  localparam logic [7:0] ADDR_GUARD      = 8'hFC;

  // reset values
  localparam logic [7:0]  RST_COUNT_HIGH = 8'hFF;
  localparam logic [7:0]  RST_COUNT_LOW  = 8'hFF;
  localparam logic [7:0]  RST_PRESCALE   = 8'hFF;
  localparam logic [7:0]  RST_CONTROL    = 8'h12;
  localparam logic [15:0] HW_GUARD_COUNT = 16'hFFFF;

  // timer_control_reg fields
  localparam int CTL_RUN       = 7;
  localparam int CTL_SINGLE    = 6;
  localparam int CTL_MODE_HI   = 5;
  localparam int CTL_MODE_LO   = 4;
  localparam int CTL_IN_EN     = 3;
  localparam int CTL_OUT_MODE  = 2;
  localparam int CTL_OUT_LEVEL = 1;
  localparam int CTL_OUT_EN    = 0;

  // guard_enable_n and watchdog reset flag both sit at bit 6
  localparam int GUARD_BIT = 6;
  localparam int FLAG_BIT  = 6;

  // input modes
  localparam logic [1:0] MODE_EVENT  = 2'h0;
  localparam logic [1:0] MODE_GATED  = 2'h1;
  localparam logic [1:0] MODE_TRIG   = 2'h2;
  localparam logic [1:0] MODE_RETRIG = 2'h3;

  // refresh sequence on count_low_reg
  localparam logic [7:0] REFRESH_FIRST  = 8'hAA;
  localparam logic [7:0] REFRESH_SECOND = 8'h55;

  // internal clock divider and strap sampling delay
  localparam logic [1:0] DIV_LAST   = 2'h3;
  localparam logic [1:0] STRAP_TAKE = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0]  const_hi;
    logic [7:0]  const_lo;
    logic [7:0]  presc;
    logic [7:0]  ctrl;
    logic        guard_n;
    logic        wd_flag;
    logic [15:0] cnt;
    logic [7:0]  presc_cnt;
    logic        new_const;
    logic        trig;
    logic        seq_armed;
    logic [1:0]  div;
    logic [2:0]  in_sync;
    logic [1:0]  strap_sync;
    logic [1:0]  strap_wait;
    logic        hw_wd;
    logic        wd_on;
    logic [7:0]  rdata;
    logic        wave;
    logic        eoc;
    logic        sys_rst;
  } state_t;

endpackage : timer_watchdog_pkg

// >>> src/timer_watchdog.sv
// timer_watchdog: 16-bit down-counter with 8-bit prescaler, timer or watchdog
// assumes clk_i is the internal clock; pins are asynchronous and synchronised here
`timescale 1ns/1ps

module timer_watchdog (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // register port
  input  wire timer_watchdog_pkg::reg_req_t  req_i,
  output logic [7:0]                         rd_data_o,
  // pins
  input  wire logic                          ext_count_input_i,
  input  wire logic                          hw_enable_strap_n_i,
  output logic                               wave_output_o,
  // system side
  output logic                               eoc_o,
  output logic                               sys_reset_o,
  output logic                               guard_active_o
);

  timer_watchdog_pkg::state_t s;
  timer_watchdog_pkg::state_t next_s;

  always_comb begin
    logic        tick;
    logic        fall;
    logic        pin_high;
    logic        wd;
    logic        run;
    logic        step;
    logic        cnt_step;
    logic        eoc_now;
    logic        load;
    logic [1:0]  mode;
    logic [15:0] const_val;
    next_s    = s;
    tick      = 1'b0;
    fall      = 1'b0;
    pin_high  = 1'b0;
    wd        = 1'b0;
    run       = 1'b0;
    step      = 1'b0;
    cnt_step  = 1'b0;
    eoc_now   = 1'b0;
    load      = 1'b0;
    mode      = 2'h0;
    const_val = 16'h0000;

    // clock/4 enable
    next_s.div = s.div + 2'h1;
    tick       = (s.div == timer_watchdog_pkg::DIV_LAST);

    // pin synchroniser; edge detect compares the second and third stages
    next_s.in_sync = {s.in_sync[1], s.in_sync[0], ext_count_input_i};
    fall           = s.in_sync[2] & ~s.in_sync[1];
    pin_high       = s.in_sync[1];

    // strap caught once, after reset release and synchroniser settle
    next_s.strap_sync = {s.strap_sync[0], hw_enable_strap_n_i};
    if (s.strap_wait != timer_watchdog_pkg::STRAP_DONE) begin
      next_s.strap_wait = s.strap_wait + 2'h1;
      if (s.strap_wait == timer_watchdog_pkg::STRAP_TAKE) begin
        next_s.hw_wd = ~s.strap_sync[1];
      end
    end

    wd        = s.hw_wd | ~s.guard_n;
    run       = s.ctrl[timer_watchdog_pkg::CTL_RUN];
    mode      = s.ctrl[timer_watchdog_pkg::CTL_MODE_HI:timer_watchdog_pkg::CTL_MODE_LO];
    const_val = s.hw_wd ? timer_watchdog_pkg::HW_GUARD_COUNT : {s.const_hi, s.const_lo};

    // count enable selection
    if (wd) begin
      step = tick;
    end else if (!run) begin
      step = 1'b0;
    end else if (!s.ctrl[timer_watchdog_pkg::CTL_IN_EN]) begin
      step = tick;
    end else begin
      case (mode)
        timer_watchdog_pkg::MODE_EVENT:  step = fall;
        timer_watchdog_pkg::MODE_GATED:  step = tick & pin_high;
        timer_watchdog_pkg::MODE_TRIG:   step = tick & s.trig;
        default:                         step = tick;
      endcase
    end
    if (fall && run) begin
      next_s.trig = 1'b1;
    end

    // register writes
    if (req_i.wr) begin
      case (req_i.addr)
        timer_watchdog_pkg::ADDR_COUNT_HIGH: begin
          if (!wd) begin
            next_s.const_hi  = req_i.wdata;
            next_s.new_const = 1'b1;
          end
        end
        timer_watchdog_pkg::ADDR_COUNT_LOW: begin
          if (wd) begin
            if (req_i.wdata == timer_watchdog_pkg::REFRESH_FIRST) begin
              next_s.seq_armed = 1'b1;
            end else if (s.seq_armed && req_i.wdata == timer_watchdog_pkg::REFRESH_SECOND) begin
              next_s.seq_armed = 1'b0;
              load             = 1'b1;
            end else begin
              next_s.seq_armed = 1'b0;
            end
          end else begin
            next_s.const_lo  = req_i.wdata;
            next_s.new_const = 1'b1;
          end
        end
        timer_watchdog_pkg::ADDR_PRESCALE: begin
          next_s.presc     = req_i.wdata;
          next_s.presc_cnt = req_i.wdata;
        end
        timer_watchdog_pkg::ADDR_CONTROL: begin
          next_s.ctrl = req_i.wdata;
          if (!wd && req_i.wdata[timer_watchdog_pkg::CTL_RUN] && !run) begin
            next_s.trig = 1'b0;
            load        = s.new_const;
          end
        end
        timer_watchdog_pkg::ADDR_GUARD: begin
          if (!req_i.wdata[timer_watchdog_pkg::GUARD_BIT]) begin
            next_s.guard_n = 1'b0;
            load           = s.guard_n & ~s.hw_wd;
          end
        end
        timer_watchdog_pkg::ADDR_FLAG: begin
          if (!req_i.wdata[timer_watchdog_pkg::FLAG_BIT]) begin
            next_s.wd_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // prescaler then counter
    if (step) begin
      if (s.presc_cnt == 8'h00) begin
        next_s.presc_cnt = s.presc;
        cnt_step         = 1'b1;
      end else begin
        next_s.presc_cnt = s.presc_cnt - 8'h01;
      end
    end
    eoc_now = cnt_step && (s.cnt == 16'h0000);
    if (cnt_step) begin
      if (eoc_now) begin
        next_s.cnt       = const_val;
        next_s.new_const = 1'b0;
        if (!wd && s.ctrl[timer_watchdog_pkg::CTL_SINGLE]) begin
          next_s.ctrl[timer_watchdog_pkg::CTL_RUN] = 1'b0;
        end
      end else begin
        next_s.cnt = s.cnt - 16'h0001;
      end
    end

    // retrigger reload only while running
    if (!wd && run && s.ctrl[timer_watchdog_pkg::CTL_IN_EN]
        && mode == timer_watchdog_pkg::MODE_RETRIG && fall) begin
      load = 1'b1;
    end

    // explicit loads win over counting in the same cycle
    if (load) begin
      next_s.cnt       = const_val;
      next_s.presc_cnt = s.presc;
      next_s.new_const = 1'b0;
    end

    // end-of-count consequences; flag set beats a same-cycle clear
    next_s.eoc     = eoc_now & ~wd;
    next_s.sys_rst = eoc_now & wd;
    if (eoc_now && wd) begin
      next_s.wd_flag = 1'b1;
    end
    next_s.wd_on = next_s.hw_wd | ~next_s.guard_n;

    // output pin
    if (!s.ctrl[timer_watchdog_pkg::CTL_OUT_EN]) begin
      next_s.wave = 1'b1;
    end else if (eoc_now) begin
      if (s.ctrl[timer_watchdog_pkg::CTL_OUT_MODE]) begin
        next_s.wave = s.ctrl[timer_watchdog_pkg::CTL_OUT_LEVEL];
      end else begin
        next_s.wave = ~s.wave;
      end
    end

    // read data stands one cycle only
    next_s.rdata = 8'h00;
    if (req_i.rd) begin
      case (req_i.addr)
        timer_watchdog_pkg::ADDR_COUNT_HIGH: next_s.rdata = s.cnt[15:8];
        timer_watchdog_pkg::ADDR_COUNT_LOW:  next_s.rdata = s.cnt[7:0];
        timer_watchdog_pkg::ADDR_PRESCALE:   next_s.rdata = s.presc;
        timer_watchdog_pkg::ADDR_CONTROL:    next_s.rdata = s.ctrl;
        timer_watchdog_pkg::ADDR_GUARD:      next_s.rdata = {1'b0, s.guard_n, 6'h00};
        timer_watchdog_pkg::ADDR_FLAG:       next_s.rdata = {1'b0, s.wd_flag, 6'h00};
        default:                             next_s.rdata = 8'h00;
      endcase
    end
  end

  // strap pin is a level, so it is resampled after release, never at reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s            <= '0;
      s.const_hi   <= timer_watchdog_pkg::RST_COUNT_HIGH;
      s.const_lo   <= timer_watchdog_pkg::RST_COUNT_LOW;
      s.presc      <= timer_watchdog_pkg::RST_PRESCALE;
      s.ctrl       <= timer_watchdog_pkg::RST_CONTROL;
      s.guard_n    <= 1'b1;
      s.cnt        <= timer_watchdog_pkg::HW_GUARD_COUNT;
      s.presc_cnt  <= timer_watchdog_pkg::RST_PRESCALE;
      s.in_sync    <= 3'h7;
      s.strap_sync <= 2'h3;
      s.wave       <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o      = s.rdata;
  assign wave_output_o  = s.wave;
  assign eoc_o          = s.eoc;
  assign sys_reset_o    = s.sys_rst;
  assign guard_active_o = s.wd_on;

endmodule : timer_watchdog

// >>> tb/pin_partner.sv
// pin_partner: count input pin source and system reset tally
// assumes start_i is a one-cycle pulse after a clock edge
`timescale 1ns/1ps
module pin_partner (
  // clock
  input  wire logic       clk_i,
  // commands
  input  wire logic       start_i,
  input  wire logic [7:0] n_edges_i,
  // pins
  input  wire logic       sys_reset_i,
  output logic            pin_o,
  output int              n_resets_o
);
  initial begin
    pin_o = 1'b1;
    n_resets_o = 0;
  end
  // ten clocks between falling edges, safely above the minimum spacing
  always @(posedge clk_i) begin
    if (start_i) begin
      for (int i = 0; i < n_edges_i; i++) begin
        repeat (5) @(posedge clk_i);
        pin_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        pin_o <= 1'b1;
      end
    end
  end
  always @(posedge clk_i) begin
    if (sys_reset_i === 1'b1) n_resets_o <= n_resets_o + 1;
  end
endmodule : pin_partner

// >>> tb/timer_watchdog_assertions.sv
// timer_watchdog_assertions: port checks of the timer/watchdog
// assumes control is written only outside watchdog mode
`timescale 1ns/1ps
module timer_watchdog_assertions (
  // clock and reset
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  // register port
  input wire timer_watchdog_pkg::reg_req_t req_i,
  input wire logic [7:0]                   rd_data_o,
  // pins and system side
  input wire logic                         ext_count_input_i,
  input wire logic                         hw_enable_strap_n_i,
  input wire logic                         wave_output_o,
  input wire logic                         eoc_o,
  input wire logic                         sys_reset_o,
  input wire logic                         guard_active_o
);
  // shadow of {output mode, output enable}; single mode never touches them
  logic [1:0] out_q;
  logic       sq;
  logic       ev;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) out_q <= 2'h0;
    else if (req_i.wr && req_i.addr == 8'hFB) out_q <= {req_i.wdata[2], req_i.wdata[0]};
  end
  assign sq = out_q == 2'h1;
  assign ev = eoc_o | sys_reset_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rd_idle_zero: assert property (!$past(req_i.rd) |-> rd_data_o == 8'h00)
    else $error("read data outside read slot");
  a_eoc_one_cycle: assert property (eoc_o |=> !eoc_o)
    else $error("end of count pulse too long");
  a_eoc_timer_only: assert property (eoc_o |-> !$past(guard_active_o))
    else $error("timer pulse in watchdog mode");
  a_sysrst_needs_guard: assert property (sys_reset_o |-> $past(guard_active_o))
    else $error("system reset outside watchdog mode");
  a_wave_off_high: assert property (!out_q[0] && $past(!out_q[0]) |-> wave_output_o)
    else $error("disabled output not high");
  a_wave_toggles: assert property (ev && sq && $past(sq) && $past(sq, 2)
    |-> wave_output_o != $past(wave_output_o))
    else $error("square wave missed a toggle");
  a_wave_holds: assert property (!ev && out_q[0] && $stable(out_q) && $past(out_q) == $past(out_q, 2)
    |-> $stable(wave_output_o))
    else $error("output moved between ends of count");
  a_guard_sticky: assert property (guard_active_o |=> guard_active_o)
    else $error("watchdog mode left");
  a_guard_enter: assert property (req_i.wr && req_i.addr == 8'hFC && !req_i.wdata[6]
    |-> ##[1:2] guard_active_o)
    else $error("watchdog mode not entered");
endmodule : timer_watchdog_assertions
bind timer_watchdog timer_watchdog_assertions chk (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
  .rd_data_o(rd_data_o), .ext_count_input_i(ext_count_input_i),
  .hw_enable_strap_n_i(hw_enable_strap_n_i), .wave_output_o(wave_output_o), .eoc_o(eoc_o),
  .sys_reset_o(sys_reset_o), .guard_active_o(guard_active_o));

// >>> tb/timer_watchdog_tb.sv
// timer_watchdog_tb: directed register tests of the timer/watchdog
// assumes the partner drives the count pin and tallies system resets
`timescale 1ns/1ps
module timer_watchdog_tb;
  logic clk_i, rst_i, strap_n, start, wave, eoc, sys_rst, guard, pin;
  logic [7:0] rd_data;
  timer_watchdog_pkg::reg_req_t req;
  int n_mismatch = 0, comparisons = 0, cyc = 0, n_eoc = 0, t_last = 0, t_prev = 0, n_resets;
  timer_watchdog dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rd_data_o(rd_data),
    .ext_count_input_i(pin), .hw_enable_strap_n_i(strap_n), .wave_output_o(wave),
    .eoc_o(eoc), .sys_reset_o(sys_rst), .guard_active_o(guard));
  pin_partner far (.clk_i(clk_i), .start_i(start), .n_edges_i(8'h0A),
    .sys_reset_i(sys_rst), .pin_o(pin), .n_resets_o(n_resets));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (eoc === 1'b1) begin
      n_eoc <= n_eoc + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input string what, input logic [15:0] e, s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    req <= '0;
    @(posedge clk_i);
  endtask : wr
  task automatic rdc(input string what, input logic [7:0] a, e);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    req <= '0;
    #1 chk(what, {8'h00, e}, {8'h00, rd_data});
    @(posedge clk_i);
  endtask : rdc
  task automatic eocs(input int n);
    int s;
    s = n_eoc;
    for (int i = 0; i < 2000 && n_eoc < s + n; i++) @(posedge clk_i);
  endtask : eocs
  initial begin
    int s;
    rst_i = 1'b1;
    strap_n = 1'b1;
    start = 1'b0;
    req = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("control", 8'hFB, 8'h12);
    rdc("count high", 8'hF8, 8'hFF);
    rdc("unmapped", 8'h10, 8'h00);
    chk("wave idle", 16'h1, wave);
    wr(8'hFA, 8'h00);
    wr(8'hF8, 8'h00);
    wr(8'hF9, 8'h03);
    wr(8'hFB, 8'h81);
    eocs(2);
    chk("period", 16'h10, 16'(t_last - t_prev));
    wr(8'hF9, 8'h07);
    eocs(1);
    chk("old period", 16'h10, 16'(t_last - t_prev));
    eocs(1);
    chk("new period", 16'h20, 16'(t_last - t_prev));
    wr(8'hFB, 8'h00);
    s = n_eoc;
    repeat (64) @(posedge clk_i);
    chk("stopped", s, n_eoc);
    chk("wave off", 16'h1, wave);
    wr(8'hFB, 8'hC5);
    eocs(1);
    s = n_eoc;
    chk("level out", 16'h0, wave);
    rdc("run cleared", 8'hFB, 8'h45);
    rdc("reloaded", 8'hF9, 8'h07);
    repeat (64) @(posedge clk_i);
    chk("single stop", s, n_eoc);
    wr(8'hF9, 8'h02);
    wr(8'hFB, 8'h88);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    repeat (110) @(posedge clk_i);
    chk("events", s + 3, n_eoc);
    wr(8'hFB, 8'h00);
    wr(8'hF9, 8'h40);
    wr(8'hFC, 8'h00);
    // guard_active_o rises on the first edge of wr, a cycle before wr ends; look mid-cycle
    @(negedge clk_i);
    chk("guard", 16'h1, {15'h0000, guard});
    @(posedge clk_i);
    for (int i = 0; i < 3; i++) begin
      repeat (200) @(posedge clk_i);
      wr(8'hF9, 8'hAA);
      wr(8'hF9, 8'h55);
    end
    chk("no reset", 16'h0, n_resets);
    repeat (150) @(posedge clk_i);
    wr(8'hF9, 8'hAA);
    wr(8'hF9, 8'h12);
    wr(8'hF9, 8'h55);
    wr(8'hFC, 8'h40);
    chk("guard kept", 16'h1, guard);
    repeat (130) @(posedge clk_i);
    chk("reset", 16'h1, n_resets);
    rdc("flag", 8'hF2, 8'h40);
    strap_n <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("strap guard", 16'h1, guard);
    results();
  end
endmodule : timer_watchdog_tb
